// >>> hdl/nv_table_access.sv
// Table read/write engine, control register and long write timer.
// Assumes core SFR and table requests synchronous to CORE_CLK_IN.
`timescale 1ns/10ps
module nv_table_access #(
    parameter int LONG_OP_CYCLES = nv_table_pkg::LONG_OP_CYCLES,
    parameter int TIMER_W = nv_table_pkg::TIMER_W
) (
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    input wire nv_table_pkg::sfr_req_t SFR_REQ_IN,
    output logic [7:0] SFR_RDATA_OUT,
    input wire nv_table_pkg::tbl_req_t TBL_REQ_IN,
    output logic TBL_READY_OUT,
    input wire logic EXT_RESET_EVENT_IN,
    input wire logic WDT_RESET_EVENT_IN,
    input wire logic NV_DONE_CLR_IN,
    output logic NV_DONE_FLAG_OUT,
    output logic FETCH_STALL_OUT,
    output logic [21:0] FLASH_RD_ADDR_OUT,
    input wire logic [15:0] FLASH_RD_WORD_IN,
    output nv_table_pkg::flash_cmd_t FLASH_CMD_OUT,
    output logic [63:0] HOLD_DATA_OUT,
    output logic EE_READ_OUT
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        nv_table_pkg::ctrl_state_t state;
        nv_table_pkg::key_stage_t key;
        nv_table_pkg::ctrl_bits_t ctrl;
        logic [7:0] latch;
        logic [nv_table_pkg::PTR_W-1:0] ptr;
        logic [nv_table_pkg::HOLD_COUNT-1:0][7:0] hold;
        logic [nv_table_pkg::PTR_W-1:0] rd_addr;
        logic [TIMER_W-1:0] timer;
        logic done_flag;
        logic [7:0] sfr_rdata;
        logic ee_read;
        nv_table_pkg::flash_cmd_t cmd;
    } st_t;

    st_t q;
    st_t d;

    localparam logic [TIMER_W-1:0] TIMER_LOAD = TIMER_W'(LONG_OP_CYCLES - 1);

    // Step low 21 bits only, top bit kept
    function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic down);
        logic [20:0] low;
        low = down ? (p[20:0] - 21'h00_0001) : (p[20:0] + 21'h00_0001);
        return {p[21], low};
    endfunction : ptr_step

    function automatic nv_table_pkg::target_t pick_target(input nv_table_pkg::ctrl_bits_t c);
        if (c.cfg_sel) begin
            return nv_table_pkg::TGT_CONFIG;
        end else if (c.pgm_sel) begin
            return nv_table_pkg::TGT_PROGRAM;
        end
        return nv_table_pkg::TGT_EEPROM;
    endfunction : pick_target

    logic tbl_take;
    logic long_done;
    logic long_abort;
    logic [21:0] eff_addr;
    logic start_ok;

    assign tbl_take = (q.state == nv_table_pkg::ST_IDLE) && TBL_REQ_IN.valid;
    assign long_done = (q.state == nv_table_pkg::ST_LONG_OP) && (q.timer == '0);
    assign long_abort = (q.state == nv_table_pkg::ST_LONG_OP)
        && (EXT_RESET_EVENT_IN || WDT_RESET_EVENT_IN);
    assign eff_addr = (TBL_REQ_IN.mode == nv_table_pkg::PTR_PRE_INC)
        ? ptr_step(q.ptr, 1'b0) : q.ptr;
    assign start_ok = SFR_REQ_IN.wr && (SFR_REQ_IN.addr == nv_table_pkg::CTRL_ADDR)
        && SFR_REQ_IN.wdata[1] && !q.ctrl.wr && q.ctrl.permit
        && (q.key == nv_table_pkg::KEY_ARMED)
        && (q.state == nv_table_pkg::ST_IDLE) && !TBL_REQ_IN.valid;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        d = q;
        d.cmd.prog_start = 1'b0;
        d.cmd.erase_start = 1'b0;
        d.ee_read = 1'b0;
        d.ctrl.rd = 1'b0;
        d.ctrl.unused = 1'b0;

        // Table operations
        if (q.state == nv_table_pkg::ST_TBL_READ) begin
            d.latch = q.rd_addr[0] ? FLASH_RD_WORD_IN[15:8] : FLASH_RD_WORD_IN[7:0];
            d.state = nv_table_pkg::ST_IDLE;
        end
        if (tbl_take) begin
            if (TBL_REQ_IN.write) begin
                d.hold[eff_addr[2:0]] = q.latch;
            end else begin
                d.rd_addr = eff_addr;
                d.state = nv_table_pkg::ST_TBL_READ;
            end
            if (TBL_REQ_IN.mode == nv_table_pkg::PTR_PRE_INC) begin
                d.ptr = eff_addr;
            end else if (TBL_REQ_IN.mode == nv_table_pkg::PTR_POST_INC) begin
                d.ptr = ptr_step(q.ptr, 1'b0);
            end else if (TBL_REQ_IN.mode == nv_table_pkg::PTR_POST_DEC) begin
                d.ptr = ptr_step(q.ptr, 1'b1);
            end
        end

        // Register reads
        if (SFR_REQ_IN.rd) begin
            if (SFR_REQ_IN.addr == nv_table_pkg::CTRL_ADDR) begin
                d.sfr_rdata = {q.ctrl[7:6], 1'b0, q.ctrl[4:0]};
            end else if (SFR_REQ_IN.addr == nv_table_pkg::LATCH_ADDR) begin
                d.sfr_rdata = q.latch;
            end else if (SFR_REQ_IN.addr == nv_table_pkg::PTR_LOW_ADDR) begin
                d.sfr_rdata = q.ptr[7:0];
            end else if (SFR_REQ_IN.addr == nv_table_pkg::PTR_HIGH_ADDR) begin
                d.sfr_rdata = q.ptr[15:8];
            end else if (SFR_REQ_IN.addr == nv_table_pkg::PTR_UPPER_ADDR) begin
                d.sfr_rdata = {2'b00, q.ptr[21:16]};
            end else begin
                d.sfr_rdata = 8'h00;
            end
        end

        // Register writes, ahead of table pointer steps
        if (SFR_REQ_IN.wr) begin
            d.key = nv_table_pkg::KEY_IDLE;
            if (SFR_REQ_IN.addr == nv_table_pkg::CTRL_ADDR) begin
                d.ctrl.pgm_sel = SFR_REQ_IN.wdata[7];
                d.ctrl.cfg_sel = SFR_REQ_IN.wdata[6];
                d.ctrl.erase_en = SFR_REQ_IN.wdata[4];
                d.ctrl.abort = SFR_REQ_IN.wdata[3];
                d.ctrl.permit = SFR_REQ_IN.wdata[2];
                if (SFR_REQ_IN.wdata[0] && !q.ctrl.pgm_sel) begin
                    d.ctrl.rd = 1'b1;
                    d.ee_read = 1'b1;
                end
                if (start_ok) begin
                    d.ctrl.wr = 1'b1;
                    d.state = nv_table_pkg::ST_LONG_OP;
                    d.timer = TIMER_LOAD;
                    d.cmd.target = pick_target(d.ctrl);
                    if (d.ctrl.erase_en && (d.cmd.target != nv_table_pkg::TGT_EEPROM)) begin
                        d.cmd.erase_start = 1'b1;
                        d.cmd.block_addr = {q.ptr[21:6], 6'h00};
                    end else if (d.cmd.target == nv_table_pkg::TGT_EEPROM) begin
                        d.cmd.prog_start = 1'b1;
                        d.cmd.block_addr = q.ptr;
                    end else begin
                        d.cmd.prog_start = 1'b1;
                        d.cmd.block_addr = {q.ptr[21:3], 3'h0};
                    end
                end
            end else if (SFR_REQ_IN.addr == nv_table_pkg::KEY_ADDR) begin
                if (SFR_REQ_IN.wdata == nv_table_pkg::KEY_FIRST) begin
                    d.key = nv_table_pkg::KEY_HALF;
                end else if ((SFR_REQ_IN.wdata == nv_table_pkg::KEY_SECOND)
                        && (q.key == nv_table_pkg::KEY_HALF)) begin
                    d.key = nv_table_pkg::KEY_ARMED;
                end
            end else if (SFR_REQ_IN.addr == nv_table_pkg::LATCH_ADDR) begin
                d.latch = SFR_REQ_IN.wdata;
            end else if (SFR_REQ_IN.addr == nv_table_pkg::PTR_LOW_ADDR) begin
                d.ptr[7:0] = SFR_REQ_IN.wdata;
            end else if (SFR_REQ_IN.addr == nv_table_pkg::PTR_HIGH_ADDR) begin
                d.ptr[15:8] = SFR_REQ_IN.wdata;
            end else if (SFR_REQ_IN.addr == nv_table_pkg::PTR_UPPER_ADDR) begin
                d.ptr[21:16] = SFR_REQ_IN.wdata[5:0];
            end
        end

        // Self-timed long operation, hardware wins over software
        if (long_abort) begin
            d.state = nv_table_pkg::ST_IDLE;
            d.ctrl.wr = 1'b0;
            d.ctrl.abort = 1'b1;
        end else if (long_done) begin
            d.state = nv_table_pkg::ST_IDLE;
            d.ctrl.wr = 1'b0;
            d.ctrl.abort = 1'b0;
            if (q.cmd.erase_start || (q.ctrl.erase_en && q.cmd.target != nv_table_pkg::TGT_EEPROM)) begin
                d.ctrl.erase_en = 1'b0;
            end
        end else if (q.state == nv_table_pkg::ST_LONG_OP) begin
            d.timer = q.timer - TIMER_W'(1);
        end

        d.done_flag = (q.done_flag && !NV_DONE_CLR_IN) || (long_done && !long_abort);
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            q <= '0;
            q.state <= nv_table_pkg::ST_IDLE;
            q.key <= nv_table_pkg::KEY_IDLE;
            q.ctrl <= nv_table_pkg::CTRL_RESET;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign SFR_RDATA_OUT = q.sfr_rdata;
    assign TBL_READY_OUT = (q.state == nv_table_pkg::ST_IDLE);
    assign NV_DONE_FLAG_OUT = q.done_flag;
    assign FETCH_STALL_OUT = (q.state == nv_table_pkg::ST_LONG_OP)
        && (q.cmd.target != nv_table_pkg::TGT_EEPROM);
    assign FLASH_RD_ADDR_OUT = q.rd_addr;
    assign FLASH_CMD_OUT = q.cmd;
    assign HOLD_DATA_OUT = q.hold;
    assign EE_READ_OUT = q.ee_read;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (RST_IN);

    logic key_write_55;
    logic key_write_aa;
    logic ctrl_write;
    assign key_write_55 = SFR_REQ_IN.wr && (SFR_REQ_IN.addr == nv_table_pkg::KEY_ADDR)
        && (SFR_REQ_IN.wdata == nv_table_pkg::KEY_FIRST);
    assign key_write_aa = SFR_REQ_IN.wr && (SFR_REQ_IN.addr == nv_table_pkg::KEY_ADDR)
        && (SFR_REQ_IN.wdata == nv_table_pkg::KEY_SECOND);
    assign ctrl_write = SFR_REQ_IN.wr && (SFR_REQ_IN.addr == nv_table_pkg::CTRL_ADDR);

    sequence unlock_seq;
        key_write_55 ##1 !SFR_REQ_IN.wr ##1 key_write_aa;
    endsequence

    sequence launch_seq;
        ctrl_write && SFR_REQ_IN.wdata[1] && q.ctrl.permit && !q.ctrl.wr
            && TBL_READY_OUT && !TBL_REQ_IN.valid;
    endsequence

    unlock_launch_a: assert property (unlock_seq ##1 !SFR_REQ_IN.wr ##1 launch_seq
        |=> q.ctrl.wr
        ##0 q.state == nv_table_pkg::ST_LONG_OP)
        else $error("Unlocked launch did not start long operation");

    launch_needs_key_a: assert property ($rose(q.ctrl.wr) |->
        $past(q.key) == nv_table_pkg::KEY_ARMED && $past(q.ctrl.permit))
        else $error("Long operation started without key or permit");

    stall_during_flash_a: assert property (
        q.ctrl.wr && FLASH_CMD_OUT.target != nv_table_pkg::TGT_EEPROM |-> FETCH_STALL_OUT)
        else $error("Fetch not stalled during flash long operation");

    key_reads_zero_a: assert property (SFR_REQ_IN.rd
        && SFR_REQ_IN.addr == nv_table_pkg::KEY_ADDR |=> SFR_RDATA_OUT == 8'h00)
        else $error("Key port read returned nonzero");

    read_start_pulse_a: assert property (q.ctrl.rd |-> EE_READ_OUT
        ##0 !$past(q.ctrl.pgm_sel) ##1 (!q.ctrl.rd || $past(ctrl_write)))
        else $error("Read start not a single cycle for data EEPROM");

    ptr_top_kept_a: assert property (tbl_take && !SFR_REQ_IN.wr
        |=> q.ptr[21] == $past(q.ptr[21]))
        else $error("Pointer step changed top bit");

    hold_fill_a: assert property (tbl_take && TBL_REQ_IN.write
        && TBL_REQ_IN.mode != nv_table_pkg::PTR_PRE_INC
        |=> q.hold[$past(q.ptr[2:0])] == $past(q.latch))
        else $error("Holding register not loaded from latch");

    erase_clears_a: assert property (long_done && !long_abort && q.cmd.target
        != nv_table_pkg::TGT_EEPROM && q.ctrl.erase_en |=> !q.ctrl.erase_en)
        else $error("Row erase enable not cleared after erase");

    done_sets_flag_a: assert property (long_done && !long_abort
        |=> NV_DONE_FLAG_OUT && !q.ctrl.wr && !q.ctrl.abort)
        else $error("Completion did not set done flag");

    abort_traced_a: assert property (long_abort |=> q.ctrl.abort
        && q.ctrl.pgm_sel == $past(q.ctrl.pgm_sel) && q.ctrl.cfg_sel == $past(q.ctrl.cfg_sel))
        else $error("Abort flag or select bits wrong after abort");

    start_sticky_a: assert property (q.ctrl.wr && !long_done && !long_abort
        |=> q.ctrl.wr)
        else $error("Write start cleared before completion");

    erase_block_a: assert property (FLASH_CMD_OUT.erase_start
        |-> FLASH_CMD_OUT.block_addr[5:0] == 6'h00)
        else $error("Erase block address not row aligned");

    permit_after_reset_a: assert property ($fell(RST_IN) |-> !q.ctrl.permit
        && !q.ctrl.wr)
        else $error("Write permit or start set after reset");

    read_blocks_a: assert property (tbl_take && !TBL_REQ_IN.write
        |=> !TBL_READY_OUT ##1 TBL_READY_OUT)
        else $error("Table read did not take one extra cycle");

    latch_from_word_a: assert property (q.state == nv_table_pkg::ST_TBL_READ
        && !(SFR_REQ_IN.wr && SFR_REQ_IN.addr == nv_table_pkg::LATCH_ADDR)
        |=> q.latch == ($past(FLASH_RD_ADDR_OUT[0]) ? $past(FLASH_RD_WORD_IN[15:8])
        : $past(FLASH_RD_WORD_IN[7:0])))
        else $error("Table latch not loaded with addressed byte");

    read_addr_full_a: assert property (tbl_take && !TBL_REQ_IN.write
        && TBL_REQ_IN.mode != nv_table_pkg::PTR_PRE_INC
        |=> FLASH_RD_ADDR_OUT == $past(q.ptr))
        else $error("Table read address not the full pointer");

    pre_inc_addr_a: assert property (tbl_take && !TBL_REQ_IN.write
        && TBL_REQ_IN.mode == nv_table_pkg::PTR_PRE_INC
        |=> FLASH_RD_ADDR_OUT[20:0] == $past(q.ptr[20:0]) + 21'h00_0001)
        else $error("Pre-increment read used wrong address");

    keep_mode_a: assert property (tbl_take && !SFR_REQ_IN.wr
        && TBL_REQ_IN.mode == nv_table_pkg::PTR_KEEP |=> q.ptr == $past(q.ptr))
        else $error("Pointer moved in keep mode");

    post_dec_step_a: assert property (tbl_take && !SFR_REQ_IN.wr
        && TBL_REQ_IN.mode == nv_table_pkg::PTR_POST_DEC
        |=> q.ptr[20:0] == $past(q.ptr[20:0]) - 21'h00_0001)
        else $error("Post-decrement step wrong");

    prog_block_a: assert property (FLASH_CMD_OUT.prog_start
        && FLASH_CMD_OUT.target != nv_table_pkg::TGT_EEPROM
        |-> FLASH_CMD_OUT.block_addr[2:0] == 3'h0)
        else $error("Program block address not aligned");

    start_one_shot_a: assert property (FLASH_CMD_OUT.prog_start
        || FLASH_CMD_OUT.erase_start
        |=> !FLASH_CMD_OUT.prog_start && !FLASH_CMD_OUT.erase_start)
        else $error("Start command longer than one cycle");

    cfg_target_a: assert property ($rose(q.ctrl.wr) && q.ctrl.cfg_sel
        |-> FLASH_CMD_OUT.target == nv_table_pkg::TGT_CONFIG)
        else $error("Config select did not override target");

    pgm_target_a: assert property ($rose(q.ctrl.wr) && !q.ctrl.cfg_sel
        |-> FLASH_CMD_OUT.target == (q.ctrl.pgm_sel ? nv_table_pkg::TGT_PROGRAM
        : nv_table_pkg::TGT_EEPROM))
        else $error("Program select did not pick target");

    abort_no_done_a: assert property (long_abort && !NV_DONE_FLAG_OUT
        |=> !NV_DONE_FLAG_OUT)
        else $error("Aborted write set done flag");

    stall_release_a: assert property (long_done && !long_abort
        |=> !FETCH_STALL_OUT && TBL_READY_OUT)
        else $error("Core not released after long operation");

endmodule : nv_table_access

// >>> hdl/nv_table_pkg.sv
// Constants and types for the program flash table access block.
// Assumes a byte-wide special function register port from the core.
//
// Overview of operation
// - Read bytes singly, program 8, erase 64.
// - No bulk erase reachable from code.
// - Stall fetch until timer ends flash long write; EEPROM writes do not stall.
// - Any stored value accepted; invalid executes as no-op.
// - Wide program space moves through byte latch.
// - Table write fills holding register by pointer.
// - Key port stores nothing, reads zero.
// - Program select picks flash over EEPROM.
// - Config select overrides program select.
// - Row erase bit erases row, self-clears.
// - Write permit gates all writes, clear after power-up.
// - Reset during write sets abort flag.
// - Abort leaves both select bits unchanged.
// - Write start set-only, hardware clears at end.
// - Completion sets sticky done flag.
// - Read start one-cycle, self-clears, refused while program select already set.
// - Three pointer bytes form 22-bit address.
// - Pointer steps change only low 21 bits.
// - Four pointer update modes per table operation.
// - Table read uses all 22 pointer bits.
// - Flash long write block from pointer bits 21:3; EEPROM uses the full pointer.
// - Row erase block from pointer bits 21:6.
package nv_table_pkg;
    localparam logic [11:0] CTRL_ADDR = 12'h0fa6;
    localparam logic [11:0] KEY_ADDR = 12'h0fa7;
    localparam logic [11:0] LATCH_ADDR = 12'h0fa8;
    localparam logic [11:0] PTR_LOW_ADDR = 12'h0fa9;
    localparam logic [11:0] PTR_HIGH_ADDR = 12'h0faa;
    localparam logic [11:0] PTR_UPPER_ADDR = 12'h0fab;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int PTR_W = 22;
    localparam int PTR_LOW_W = 21;
    localparam int HOLD_COUNT = 8;
    localparam int WRITE_BLOCK_BITS = 3;
    localparam int ERASE_BLOCK_BITS = 6;
    localparam int CLK_PERIOD_NS = 8;
    localparam int LONG_OP_TIME_NS = 2000000;
    localparam int LONG_OP_CYCLES = LONG_OP_TIME_NS / CLK_PERIOD_NS;
    localparam int TIMER_W = 18;

    typedef enum logic [1:0] {PTR_KEEP, PTR_POST_INC, PTR_POST_DEC, PTR_PRE_INC} ptr_mode_t;
    typedef enum logic [1:0] {ST_IDLE, ST_TBL_READ, ST_LONG_OP} ctrl_state_t;
    typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} key_stage_t;
    typedef enum logic [1:0] {TGT_EEPROM, TGT_PROGRAM, TGT_CONFIG} target_t;

    // Control register, bit 7 first
    typedef struct packed {
        logic pgm_sel;
        logic cfg_sel;
        logic unused;
        logic erase_en;
        logic abort;
        logic permit;
        logic wr;
        logic rd;
    } ctrl_bits_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        ptr_mode_t mode;
    } tbl_req_t;

    typedef struct packed {
        logic prog_start;
        logic erase_start;
        target_t target;
        logic [PTR_W-1:0] block_addr;
    } flash_cmd_t;
endpackage : nv_table_pkg

// >>> dv/flash_array_model.sv
// Behavioural program flash array feeding the table read path.
// Assumes a combinational read of the word at the byte address.
`timescale 1ns/10ps
module flash_array_model (
    input wire logic [21:0] ADDR_IN,
    output logic [15:0] WORD_OUT
);
    ////////////////////////////////////////////////////////////////////////
    // Word content depends on the top pointer bit too
    assign WORD_OUT = {ADDR_IN[8:1] ^ {ADDR_IN[21], 7'h00}, ~ADDR_IN[8:1]};
endmodule : flash_array_model

// >>> dv/tb.sv
// Self-checking bench for the table access block.
// Assumes the flash array model drives the read word.
`timescale 1ns/10ps
module tb;
    logic clk = 0;
    logic rst = 1;
    logic ext_ev = 0;
    logic wdt_ev = 0;
    logic done_clr = 0;
    nv_table_pkg::sfr_req_t sfr_req = '0;
    nv_table_pkg::tbl_req_t tbl_req = '0;
    logic [7:0] rdata;
    logic ready;
    logic done;
    logic stall;
    logic ee_rd;
    logic [21:0] fl_addr;
    logic [15:0] fl_word;
    logic [63:0] hold;
    nv_table_pkg::flash_cmd_t cmd;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    logic [21:0] rd_addr;
    logic [63:0] exp_hold;
    logic [21:0] st[4] = '{22'h20_0005, 22'h1f_ffff, 22'h20_0000, 22'h00_000e};
    logic [21:0] ad[4] = '{22'h20_0005, 22'h1f_ffff, 22'h20_0000, 22'h00_000f};
    logic [21:0] af[4] = '{22'h20_0005, 22'h00_0000, 22'h3f_ffff, 22'h00_000f};

    nv_table_access #(.LONG_OP_CYCLES(20), .TIMER_W(18)) DUT (
        .CORE_CLK_IN(clk), .RST_IN(rst), .SFR_REQ_IN(sfr_req), .SFR_RDATA_OUT(rdata),
        .TBL_REQ_IN(tbl_req), .TBL_READY_OUT(ready), .EXT_RESET_EVENT_IN(ext_ev),
        .WDT_RESET_EVENT_IN(wdt_ev), .NV_DONE_CLR_IN(done_clr), .NV_DONE_FLAG_OUT(done),
        .FETCH_STALL_OUT(stall), .FLASH_RD_ADDR_OUT(fl_addr), .FLASH_RD_WORD_IN(fl_word),
        .FLASH_CMD_OUT(cmd), .HOLD_DATA_OUT(hold), .EE_READ_OUT(ee_rd)
    );
    flash_array_model flash (.ADDR_IN(fl_addr), .WORD_OUT(fl_word));

    ////////////////////////////////////////////////////////////////////////
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic conclude();
        if (num_errors == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [7:0] exp_byte(input logic [21:0] a);
        return a[0] ? (a[8:1] ^ {a[21], 7'h00}) : ~a[8:1];
    endfunction : exp_byte

    ////////////////////////////////////////////////////////////////////////
    // Register port and table operation drivers
    task automatic sfr_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        sfr_req <= '0;
    endtask : sfr_wr

    task automatic sfr_rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk);
        sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        sfr_req <= '0;
        #1;
        check(rdata, e);
    endtask : sfr_rd

    task automatic set_ptr(input logic [21:0] p);
        sfr_wr(nv_table_pkg::PTR_LOW_ADDR, p[7:0]);
        sfr_wr(nv_table_pkg::PTR_HIGH_ADDR, p[15:8]);
        sfr_wr(nv_table_pkg::PTR_UPPER_ADDR, {2'b00, p[21:16]});
    endtask : set_ptr

    task automatic chk_ptr(input logic [21:0] p);
        sfr_rd(nv_table_pkg::PTR_LOW_ADDR, p[7:0]);
        sfr_rd(nv_table_pkg::PTR_HIGH_ADDR, p[15:8]);
        sfr_rd(nv_table_pkg::PTR_UPPER_ADDR, {2'b00, p[21:16]});
    endtask : chk_ptr

    task automatic tbl_op(input logic w, input nv_table_pkg::ptr_mode_t m);
        @(posedge clk);
        tbl_req <= '{valid: 1'b1, write: w, mode: m};
        @(posedge clk);
        tbl_req <= '0;
        #1;
        rd_addr = fl_addr;
        repeat (2) @(posedge clk);
        #1;
        check(ready, 1'b1);
    endtask : tbl_op

    // Unlock, launch and check the command pulse
    task automatic long_op(input logic [7:0] c, input nv_table_pkg::target_t tg,
                           input logic [21:0] blk);
        sfr_wr(nv_table_pkg::CTRL_ADDR, c & 8'hfd);
        sfr_wr(nv_table_pkg::KEY_ADDR, nv_table_pkg::KEY_FIRST);
        sfr_wr(nv_table_pkg::KEY_ADDR, nv_table_pkg::KEY_SECOND);
        sfr_wr(nv_table_pkg::CTRL_ADDR, c);
        #1;
        check(stall, tg != nv_table_pkg::TGT_EEPROM);
        check(cmd.erase_start, c[4]);
        check(cmd.prog_start, !c[4]);
        check(cmd.target, tg);
        check(cmd.block_addr, blk);
    endtask : long_op

    task automatic wait_done();
        for (int i = 0; i < 60 && done !== 1'b1; i++) @(posedge clk);
        #1;
        check(done, 1'b1);
        check(stall, 1'b0);
        @(posedge clk);
        done_clr <= 1'b1;
        @(posedge clk);
        done_clr <= 1'b0;
        #1;
        check(done, 1'b0);
    endtask : wait_done

    task automatic abort_case(input logic src, input logic [7:0] c,
                              input nv_table_pkg::target_t tg, input logic [21:0] p,
                              input logic [21:0] blk, input logic [7:0] e);
        set_ptr(p);
        long_op(c, tg, blk);
        repeat (3) @(posedge clk);
        if (src) wdt_ev <= 1'b1;
        else ext_ev <= 1'b1;
        @(posedge clk);
        wdt_ev <= 1'b0;
        ext_ev <= 1'b0;
        @(posedge clk);
        #1;
        check(stall, 1'b0);
        check(done, 1'b0);
        sfr_rd(nv_table_pkg::CTRL_ADDR, e);
        check(ready, 1'b1);
    endtask : abort_case

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        sfr_rd(nv_table_pkg::CTRL_ADDR, nv_table_pkg::CTRL_RESET);
        sfr_wr(nv_table_pkg::KEY_ADDR, 8'h5a);
        sfr_rd(nv_table_pkg::KEY_ADDR, 8'h00);
        sfr_rd(12'h0f00, 8'h00);
        for (int m = 0; m < 4; m++) begin
            set_ptr(st[m]);
            tbl_op(1'b0, nv_table_pkg::ptr_mode_t'(m));
            check(rd_addr, ad[m]);
            sfr_rd(nv_table_pkg::LATCH_ADDR, exp_byte(ad[m]));
            chk_ptr(af[m]);
        end
        set_ptr(22'h00_1004);
        exp_hold = '0;
        for (int i = 0; i < 8; i++) begin
            sfr_wr(nv_table_pkg::LATCH_ADDR, 8'h10 + 8'(i));
            tbl_op(1'b1, nv_table_pkg::PTR_POST_INC);
            exp_hold[8 * ((4 + i) % 8) +: 8] = 8'h10 + 8'(i);
        end
        check(hold, exp_hold);
        check(cmd.prog_start, 1'b0);
        sfr_wr(nv_table_pkg::CTRL_ADDR, 8'h84);
        sfr_wr(nv_table_pkg::CTRL_ADDR, 8'h86);
        #1;
        check(stall, 1'b0);
        sfr_wr(nv_table_pkg::CTRL_ADDR, 8'h80);
        sfr_wr(nv_table_pkg::KEY_ADDR, nv_table_pkg::KEY_FIRST);
        sfr_wr(nv_table_pkg::KEY_ADDR, nv_table_pkg::KEY_SECOND);
        sfr_wr(nv_table_pkg::CTRL_ADDR, 8'h82);
        #1;
        check(stall, 1'b0);
        sfr_rd(nv_table_pkg::CTRL_ADDR, 8'h80);
        abort_case(1'b0, 8'hd6, nv_table_pkg::TGT_CONFIG, 22'h20_1234, 22'h20_1200, 8'hdc);
        abort_case(1'b1, 8'h86, nv_table_pkg::TGT_PROGRAM, 22'h00_0abc, 22'h00_0ab8, 8'h8c);
        set_ptr(22'h00_107f);
        long_op(8'h96, nv_table_pkg::TGT_PROGRAM, 22'h00_1040);
        wait_done();
        sfr_rd(nv_table_pkg::CTRL_ADDR, 8'h84);
        set_ptr(22'h00_100c);
        long_op(8'h86, nv_table_pkg::TGT_PROGRAM, 22'h00_1008);
        sfr_wr(nv_table_pkg::CTRL_ADDR, 8'h84);
        sfr_rd(nv_table_pkg::CTRL_ADDR, 8'h86);
        wait_done();
        sfr_rd(nv_table_pkg::CTRL_ADDR, 8'h84);
        long_op(8'h06, nv_table_pkg::TGT_EEPROM, 22'h00_100c);
        wait_done();
        sfr_wr(nv_table_pkg::CTRL_ADDR, 8'h01);
        #1;
        check(ee_rd, 1'b1);
        @(posedge clk);
        #1;
        check(ee_rd, 1'b0);
        sfr_rd(nv_table_pkg::CTRL_ADDR, 8'h00);
        sfr_wr(nv_table_pkg::CTRL_ADDR, 8'h80);
        sfr_wr(nv_table_pkg::CTRL_ADDR, 8'h81);
        #1;
        check(ee_rd, 1'b0);
        sfr_rd(nv_table_pkg::CTRL_ADDR, 8'h80);
        conclude();
    end
endmodule : tb
